// File: hw/bscs_seq.sv
/*
  Command sequencer of a barometric pressure and altitude sensor: power-up
  and calibration, sleep, soft reset, conversion timing, result storage and
  result replies. Assumes a serial front end on link_clk that delivers whole
  command bytes and drains reply bytes, and an analog/compensation datapath
  on clk that presents samples and altitude continuously.
*/
// How it works
// - Power-on runs init, about 400 us, then sleep
// - Power-up-done flag set when calibration completes
// - Sleep idles until a valid command
// - Pressure conversion converts temperature first; temp-only allowed
// - Results kept through sleep for later reads
// - Phase time follows decimation; pressure doubles it
// - Compensation config picks compensated or raw results
// - Altitude updated when temp-pressure conversion ends
// - Exactly one calibration per reset, then sleep
// - Every finished command returns to sleep
// - Byte 0x06 resets immediately, abandoning work
// - Soft reset clears results, reruns power-up
// - Conversion byte: prefix 010, decimation, channel
// - Channel 00 temp plus pressure; 10 temp only
// - Decimation codes 000..101 give 4096..128
// - Bad channel or decimation code fails conversion
// - Temperature: signed 20 bits in 24-bit word
// - Pressure: unsigned 20 bits in 24-bit word
// - Altitude: signed 20 bits in 24-bit word
// - 0x10 returns temperature then pressure
// - 0x11 returns temperature then altitude
// - 0x30 returns pressure only, three bytes
// - Most significant bit and byte first
`timescale 1ns/1ns
`default_nettype none

module bscs_seq #(
  parameter int unsigned INIT_CYC = bscs_pkg::INIT_CYC,
  parameter int unsigned CONV_CYC [6] = '{bscs_pkg::CONV_CYC_4096,
    bscs_pkg::CONV_CYC_2048, bscs_pkg::CONV_CYC_1024,
    bscs_pkg::CONV_CYC_512, bscs_pkg::CONV_CYC_256,
    bscs_pkg::CONV_CYC_128}
) (
  // Core clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link side, on the link clock
  input wire logic link_clk,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  // Datapath inputs
  input wire bscs_pkg::bscs_sample_t raw_sample,
  input wire bscs_pkg::bscs_sample_t comp_sample,
  input wire logic [bscs_pkg::RES_W-1:0] alt_in,
  // Configuration and status
  input wire logic compensation_config,
  output logic [7:0] event_source_reg,
  output logic powerup_done_flag,
  output logic asleep
);

  typedef enum logic [2:0] {
    ST_INIT, ST_CAL, ST_SLEEP, ST_CONV_T, ST_CONV_P
  } bscs_state_t;

  // ****************************************************************
  // Link domain: command capture and reply shifter
  // ****************************************************************
  logic cmd_tgl_reg;
  logic [7:0] cmd_hold_reg;
  logic cmd_ack_l1_reg, cmd_ack_l2_reg;
  logic rep_l1_reg, rep_l2_reg, rep_l3_reg;
  logic rep_ack_tgl_reg;
  logic [47:0] shift_reg;
  logic [2:0] left_reg;
  // Core-domain handshake state, declared here for the link side
  logic cmd_ack_tgl_reg;
  logic rep_tgl_reg;
  bscs_pkg::bscs_reply_t reply_reg;

  // Ready while the previous byte has been acknowledged by the core
  assign cmd_ready = (cmd_tgl_reg == cmd_ack_l2_reg);
  assign tx_valid = (left_reg != 3'h0);
  assign tx_byte = shift_reg[47:40];

  // Hold a taken command byte and flag it by a toggle
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_tgl_reg <= 1'b0;
      cmd_hold_reg <= 8'h00;
    end else if (cmd_valid && cmd_ready) begin
      cmd_tgl_reg <= ~cmd_tgl_reg;
      cmd_hold_reg <= cmd_byte;
    end
  end

  // Synchronisers into the link domain
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ack_l1_reg <= 1'b0;
      cmd_ack_l2_reg <= 1'b0;
      rep_l1_reg <= 1'b0;
      rep_l2_reg <= 1'b0;
      rep_l3_reg <= 1'b0;
    end else begin
      cmd_ack_l1_reg <= cmd_ack_tgl_reg;
      cmd_ack_l2_reg <= cmd_ack_l1_reg;
      rep_l1_reg <= rep_tgl_reg;
      rep_l2_reg <= rep_l1_reg;
      rep_l3_reg <= rep_l2_reg;
    end
  end

  // Load a reply, shift bytes out MSB first, ack after the last
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 48'h0;
      left_reg <= 3'h0;
      rep_ack_tgl_reg <= 1'b0;
    end else if (rep_l2_reg != rep_l3_reg) begin
      shift_reg <= reply_reg.data;
      left_reg <= reply_reg.nbytes;
    end else if (tx_valid && tx_ready) begin
      shift_reg <= {shift_reg[39:0], 8'h00};
      left_reg <= left_reg - 3'h1;
      if (left_reg == 3'h1) begin
        rep_ack_tgl_reg <= ~rep_ack_tgl_reg;
      end
    end
  end

  // ****************************************************************
  // Core domain: command arrival and reply handshake
  // ****************************************************************
  logic cmd_c1_reg, cmd_c2_reg, cmd_c3_reg;
  logic rep_ack_c1_reg, rep_ack_c2_reg;
  logic cmd_evt, rep_pending;
  logic [7:0] cmd;
  logic is_conv, conv_ok, is_fetch;
  logic [2:0] dec_code;
  logic [1:0] chan_code;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_c1_reg <= 1'b0;
      cmd_c2_reg <= 1'b0;
      cmd_c3_reg <= 1'b0;
      rep_ack_c1_reg <= 1'b0;
      rep_ack_c2_reg <= 1'b0;
    end else begin
      cmd_c1_reg <= cmd_tgl_reg;
      cmd_c2_reg <= cmd_c1_reg;
      cmd_c3_reg <= cmd_c2_reg;
      rep_ack_c1_reg <= rep_ack_tgl_reg;
      rep_ack_c2_reg <= rep_ack_c1_reg;
    end
  end

  // The held byte is stable until the core returns the ack toggle
  assign cmd_evt = cmd_c2_reg ^ cmd_c3_reg;
  assign cmd = cmd_hold_reg;
  assign rep_pending = (rep_tgl_reg != rep_ack_c2_reg);
  assign dec_code = cmd[bscs_pkg::DEC_LSB +: 3];
  assign chan_code = cmd[1:0];
  assign is_conv = (cmd[bscs_pkg::CONV_PREFIX_LSB +: 3]
                    == bscs_pkg::CONV_PREFIX);
  assign conv_ok = (dec_code <= bscs_pkg::DEC_MAX_CODE)
                   && (chan_code == bscs_pkg::CHAN_TEMP_PRES
                   || chan_code == bscs_pkg::CHAN_TEMP_ONLY);
  assign is_fetch = (cmd == bscs_pkg::CMD_TEMP_PRESSURE_FETCH)
                    || (cmd == bscs_pkg::CMD_TEMP_ALTITUDE_FETCH)
                    || (cmd == bscs_pkg::CMD_PRESSURE_FETCH);

  // Acknowledge each command as it is seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ack_tgl_reg <= 1'b0;
    end else if (cmd_evt) begin
      cmd_ack_tgl_reg <= cmd_c2_reg;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  bscs_state_t state_reg;
  logic [23:0] cnt_reg;
  logic [2:0] dec_reg;
  logic with_pres_reg;
  logic use_comp_reg;
  logic powerup_reg;
  logic fail_reg;
  logic soft_rst;
  logic phase_end;
  bscs_pkg::bscs_result_t res_reg;

  assign soft_rst = cmd_evt && (cmd == bscs_pkg::CMD_SOFT_RESET);
  assign phase_end = (cnt_reg == 24'h0);

  // State and phase counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_INIT;
      cnt_reg <= 24'(INIT_CYC - 1);
      dec_reg <= 3'h0;
      with_pres_reg <= 1'b0;
      use_comp_reg <= 1'b0;
    end else if (soft_rst) begin
      state_reg <= ST_INIT;
      cnt_reg <= 24'(INIT_CYC - 1);
    end else begin
      unique case (state_reg)
        ST_INIT: begin
          if (phase_end) begin
            state_reg <= ST_CAL;
          end else begin
            cnt_reg <= cnt_reg - 24'h1;
          end
        end
        ST_CAL: begin
          state_reg <= ST_SLEEP;
        end
        ST_SLEEP: begin
          // Only a well-formed conversion byte or a soft reset leaves sleep
          if (cmd_evt && is_conv && conv_ok) begin
            state_reg <= ST_CONV_T;
            cnt_reg <= 24'(CONV_CYC[dec_code] - 1);
            dec_reg <= dec_code;
            with_pres_reg <= (chan_code == bscs_pkg::CHAN_TEMP_PRES);
            use_comp_reg <= compensation_config;
          end
        end
        ST_CONV_T: begin
          if (!phase_end) begin
            cnt_reg <= cnt_reg - 24'h1;
          end else if (with_pres_reg) begin
            state_reg <= ST_CONV_P;
            cnt_reg <= 24'(CONV_CYC[dec_reg] - 1);
          end else begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_CONV_P: begin
          if (!phase_end) begin
            cnt_reg <= cnt_reg - 24'h1;
          end else begin
            state_reg <= ST_SLEEP;
          end
        end
      endcase
    end
  end

  // Power-up-done and conversion-failure flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powerup_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else if (soft_rst) begin
      powerup_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      if (state_reg == ST_CAL) begin
        powerup_reg <= 1'b1;
      end
      if (state_reg == ST_SLEEP && cmd_evt && is_conv) begin
        fail_reg <= !conv_ok;
      end
    end
  end

  // Result storage; survives sleep, cleared by either reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_reg <= '{bscs_pkg::RES_DEFAULT, bscs_pkg::RES_DEFAULT,
                   bscs_pkg::RES_DEFAULT};
    end else if (soft_rst) begin
      res_reg <= '{bscs_pkg::RES_DEFAULT, bscs_pkg::RES_DEFAULT,
                   bscs_pkg::RES_DEFAULT};
    end else if (phase_end && state_reg == ST_CONV_T) begin
      res_reg.temp <= use_comp_reg
        ? {{4{comp_sample.temp[19]}}, comp_sample.temp}
        : {{4{raw_sample.temp[19]}}, raw_sample.temp};
    end else if (phase_end && state_reg == ST_CONV_P) begin
      res_reg.pres <= use_comp_reg ? {4'h0, comp_sample.pres}
                                   : {4'h0, raw_sample.pres};
      res_reg.alt <= {{4{alt_in[19]}}, alt_in};
    end
  end

  // Reply build; one reply in flight at a time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rep_tgl_reg <= 1'b0;
      reply_reg <= '0;
    end else if (cmd_evt && is_fetch && !rep_pending
                 && state_reg != ST_INIT && state_reg != ST_CAL) begin
      rep_tgl_reg <= ~rep_tgl_reg;
      if (cmd == bscs_pkg::CMD_TEMP_PRESSURE_FETCH) begin
        reply_reg <= '{bscs_pkg::REPLY_LONG,
                       {res_reg.temp, res_reg.pres}};
      end else if (cmd == bscs_pkg::CMD_TEMP_ALTITUDE_FETCH) begin
        reply_reg <= '{bscs_pkg::REPLY_LONG,
                       {res_reg.temp, res_reg.alt}};
      end else begin
        reply_reg <= '{bscs_pkg::REPLY_SHORT,
                       {res_reg.pres, 24'h000000}};
      end
    end
  end

  // Status outputs
  always_comb begin
    event_source_reg = 8'h00;
    event_source_reg[bscs_pkg::EVT_PWRUP_BIT] = powerup_reg;
    event_source_reg[bscs_pkg::EVT_FAIL_BIT] = fail_reg;
  end
  assign powerup_done_flag = powerup_reg;
  assign asleep = (state_reg == ST_SLEEP);

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [1:0] cal_cnt_reg;

  // Calibrations seen since the last reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_cnt_reg <= 2'h0;
    end else if (soft_rst) begin
      cal_cnt_reg <= 2'h0;
    end else if (state_reg == ST_CAL && cal_cnt_reg != 2'h3) begin
      cal_cnt_reg <= cal_cnt_reg + 2'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_init_then_sleep: assert property (
    state_reg == ST_INIT && phase_end && !soft_rst
    |=> state_reg == ST_CAL ##1 (state_reg == ST_SLEEP || $past(soft_rst)))
    else $error("init did not end in sleep");
  a_powerup_flag_set: assert property (
    $rose(powerup_reg) |-> $past(state_reg) == ST_CAL && asleep)
    else $error("power-up flag rose outside calibration");
  a_sleep_holds: assert property (
    state_reg == ST_SLEEP && !cmd_evt |=> state_reg == ST_SLEEP)
    else $error("left sleep without a command");
  a_temp_first: assert property (
    state_reg == ST_CONV_P && $past(state_reg) != ST_CONV_P
    |-> $past(state_reg) == ST_CONV_T)
    else $error("pressure phase without temperature phase");
  a_phase_length: assert property (
    state_reg == ST_SLEEP && cmd_evt && is_conv && conv_ok && !soft_rst
    |=> cnt_reg == 24'(CONV_CYC[$past(dec_code)] - 1))
    else $error("conversion phase length wrong");
  a_one_cal: assert property (
    cal_cnt_reg <= 2'h1)
    else $error("more than one calibration per reset");
  a_conv_back_sleep: assert property (
    state_reg == ST_CONV_P && phase_end && !soft_rst
    |=> state_reg == ST_SLEEP && res_reg.alt[19:0] == $past(alt_in))
    else $error("conversion end did not update and sleep");
  a_soft_reset: assert property (
    soft_rst |=> state_reg == ST_INIT && !powerup_reg
    && res_reg == '0)
    else $error("soft reset not immediate");
  a_bad_code_fails: assert property (
    state_reg == ST_SLEEP && cmd_evt && is_conv && !conv_ok && !soft_rst
    |=> fail_reg && state_reg == ST_SLEEP)
    else $error("bad conversion code not refused");
  a_short_reply: assert property (
    cmd_evt && cmd == bscs_pkg::CMD_PRESSURE_FETCH && !rep_pending
    && asleep |=> reply_reg.nbytes == bscs_pkg::REPLY_SHORT
    && reply_reg.data[47:24] == $past(res_reg.pres))
    else $error("pressure reply wrong");

  c_temp_pres_conv: cover property (
    state_reg == ST_CONV_P && phase_end);
  c_temp_only_conv: cover property (
    state_reg == ST_CONV_T && phase_end && !with_pres_reg);
  c_soft_reset_busy: cover property (soft_rst && !asleep);
  c_reply_done: cover property ($fell(rep_pending));

endmodule // bscs_seq

`default_nettype wire

// File: hw/bscs_pkg.sv
/*
  Shared constants and types of the barometric sensor command sequencer.
  Assumes a 125 MHz core clock; all cycle counts derive from it.
*/
package bscs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned INIT_TIME_US = 400;
  localparam int unsigned INIT_CYC =
    (INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // One conversion phase per decimation code 0..5, in ns
  localparam int unsigned CONV_NS_4096 = 65600000;
  localparam int unsigned CONV_NS_2048 = 32800000;
  localparam int unsigned CONV_NS_1024 = 16400000;
  localparam int unsigned CONV_NS_512 = 8200000;
  localparam int unsigned CONV_NS_256 = 4100000;
  localparam int unsigned CONV_NS_128 = 2100000;
  localparam int unsigned CONV_CYC_4096 = CONV_NS_4096 / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYC_2048 = CONV_NS_2048 / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYC_1024 = CONV_NS_1024 / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYC_512 = CONV_NS_512 / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYC_256 = CONV_NS_256 / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYC_128 = CONV_NS_128 / CLK_PERIOD_NS;

  // ****************************************************************
  // Command encoding
  // ****************************************************************
  localparam logic [7:0] CMD_SOFT_RESET = 8'h06;
  localparam logic [7:0] CMD_TEMP_PRESSURE_FETCH = 8'h10;
  localparam logic [7:0] CMD_TEMP_ALTITUDE_FETCH = 8'h11;
  localparam logic [7:0] CMD_PRESSURE_FETCH = 8'h30;
  localparam int unsigned CONV_PREFIX_LSB = 5;
  localparam int unsigned DEC_LSB = 2;
  localparam logic [2:0] CONV_PREFIX = 3'h2;
  localparam logic [2:0] DEC_MAX_CODE = 3'h5;
  localparam logic [1:0] CHAN_TEMP_PRES = 2'h0;
  localparam logic [1:0] CHAN_TEMP_ONLY = 2'h2;

  // ****************************************************************
  // Results, replies and status
  // ****************************************************************
  localparam int unsigned RES_W = 20;
  localparam logic [23:0] RES_DEFAULT = 24'h000000;
  localparam logic [2:0] REPLY_LONG = 3'h6;
  localparam logic [2:0] REPLY_SHORT = 3'h3;
  localparam int unsigned EVT_PWRUP_BIT = 6;
  localparam int unsigned EVT_FAIL_BIT = 0;

  typedef struct packed {
    logic [RES_W-1:0] temp;
    logic [RES_W-1:0] pres;
  } bscs_sample_t;

  typedef struct packed {
    logic [23:0] temp;
    logic [23:0] pres;
    logic [23:0] alt;
  } bscs_result_t;

  typedef struct packed {
    logic [2:0] nbytes;
    logic [47:0] data;
  } bscs_reply_t;

endpackage

// File: verification/bscs_host_model.sv
/*
  Host-side model of the command link of the barometric sequencer: offers
  command bytes and drains reply bytes, promptly or with stalls.
  Assumes a free-running link clock and that the bench calls its tasks.
*/
`timescale 1ns/1ns
`default_nettype none

module bscs_host_model (
  // Link clock
  input wire logic link_clk,
  // Command path
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  input wire logic cmd_ready,
  // Reply path
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  // ****************************************************************
  // Link driving
  // ****************************************************************
  // Quiet link at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    tx_ready = 1'b0;
  end

  // Offer one byte, held until the edge that takes it
  task automatic send(input logic [7:0] b, output logic ok);
    int n;
    @(negedge link_clk);
    cmd_valid = 1'b1;
    cmd_byte = b;
    for (n = 0; n < 64; n++) begin
      if (cmd_ready === 1'b1) break;
      @(negedge link_clk);
    end
    ok = (cmd_ready === 1'b1);
    @(posedge link_clk);
    @(negedge link_clk);
    cmd_valid = 1'b0;
    cmd_byte = ~b;  // Released data shows the inverse, never a stale copy
  endtask

  // Drain nb reply bytes; slow mode stalls every other cycle
  task automatic fetch(input int nb, input bit slow, output logic [47:0] v,
                       output logic ok);
    int got;
    int n;
    v = 48'h0;
    got = 0;
    for (n = 0; n < 400 && got < nb; n++) begin
      @(negedge link_clk);
      tx_ready = slow ? ~tx_ready : 1'b1;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        v = {v[39:0], tx_byte};
        got++;
      end
    end
    ok = (got == nb);
    @(posedge link_clk);
    @(negedge link_clk);
    tx_ready = 1'b0;
  endtask
endmodule // bscs_host_model

`default_nettype wire

// File: verification/tb.sv
/*
  Self-checking bench of the barometric sequencer: power-up, conversions
  at every decimation code, fetches, bad codes and soft reset.
  Assumes the host model file and the design package are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  // ****************************************************************
  // Set-up
  // ****************************************************************
  localparam int unsigned INIT_N = 20;
  localparam int unsigned CONV_N [6] = '{384, 192, 96, 48, 24, 12};
  // Expected words: temp and altitude sign-extended, pressure zero-extended
  localparam logic [23:0] TC = 24'hfffc02;
  localparam logic [23:0] PC = 24'h018a9e;
  localparam logic [23:0] TR = 24'h000a5c;
  localparam logic [23:0] PR = 24'h08a9e0;
  localparam logic [23:0] AX = 24'hffec78;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic compensation_config = 1'b1;
  logic cmd_valid, cmd_ready, tx_valid, tx_ready, powerup_done_flag, asleep;
  logic [7:0] cmd_byte, tx_byte, event_source_reg;
  bscs_pkg::bscs_sample_t raw_sample = {20'h00a5c, 20'h8a9e0};
  bscs_pkg::bscs_sample_t comp_sample = {20'hffc02, 20'h18a9e};
  logic [bscs_pkg::RES_W-1:0] alt_in = 20'hfec78;
  int n_fail = 0;
  int checks = 0;

  // Core clock, and link clock offset so edges never meet
  always #4 clk = ~clk;
  always begin
    #3;
    forever #24 link_clk = ~link_clk;
  end

  bscs_seq #(.INIT_CYC(INIT_N), .CONV_CYC(CONV_N)) bscs_seq_i (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .raw_sample(raw_sample),
    .comp_sample(comp_sample), .alt_in(alt_in),
    .compensation_config(compensation_config),
    .event_source_reg(event_source_reg),
    .powerup_done_flag(powerup_done_flag), .asleep(asleep));

  bscs_host_model bscs_host_model_i (
    .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_ready(cmd_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [47:0] exp,
                     input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi,
                         input int got);
    checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic hang(input string what);
    n_fail++;
    $display("mismatch %s expected done seen timeout", what);
    complete_run();
  endtask

  task automatic cmd(input logic [7:0] b);
    logic ok;
    bscs_host_model_i.send(b, ok);
    if (!ok) hang("command taken");
  endtask

  // Fetch a reply and check its bytes and that nothing follows
  task automatic rd(input logic [7:0] b, input int nb, input bit slow,
                    input logic [47:0] exp);
    logic ok;
    logic [47:0] v;
    cmd(b);
    bscs_host_model_i.fetch(nb, slow, v, ok);
    if (!ok) hang("reply bytes");
    chk("reply", exp, v);
    chk("reply end", 48'h0, {47'h0, tx_valid});
  endtask

  // Count core cycles until asleep, ready flag or fail flag reach lvl
  task automatic wait_lvl(input int sel, input logic lvl, output int n);
    logic s;
    for (n = 0; n < 5000; n++) begin
      s = (sel == 0) ? asleep : (sel == 1) ? powerup_done_flag :
          event_source_reg[0];
      if (s === lvl) return;
      @(negedge clk);
    end
    hang("status level");
  endtask

  // One conversion, timed from leaving sleep to returning
  task automatic conv(input logic [2:0] d, input logic [1:0] c,
                      input logic comp);
    int n;
    int exp;
    @(negedge clk);
    compensation_config = comp;
    cmd({3'h2, d, c});
    wait_lvl(0, 1'b0, n);
    wait_lvl(0, 1'b1, n);
    exp = CONV_N[d] * ((c == 2'h0) ? 2 : 1);
    chk_rng("conversion cycles", exp - 2, exp + 1, n);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_powerup();
    int n;
    repeat (20) @(negedge clk);
    chk("reset outputs", 48'h4, {45'h0, cmd_ready, tx_valid, asleep});
    chk("reset events", 48'h0, {40'h0, event_source_reg});
    rst_n = 1'b1;
    wait_lvl(1, 1'b1, n);
    chk_rng("init cycles", INIT_N + 1, INIT_N + 1, n);
    chk("ready state", 48'h81, {39'h0, event_source_reg, asleep});
    repeat (300) @(negedge clk);
    chk("idle sleep", 48'h1, {47'h0, asleep});
  endtask

  task automatic t_default_reads();
    rd(8'h10, 6, 0, 48'h0);
    rd(8'h11, 6, 1, 48'h0);
    rd(8'h30, 3, 0, 48'h0);
  endtask

  task automatic t_all_codes();
    for (int d = 0; d < 6; d++) begin
      conv(d[2:0], 2'h0, 1'b1);
      rd(8'h10, 6, 0, {TC, PC});
    end
    rd(8'h11, 6, 1, {TC, AX});
  endtask

  task automatic t_raw_temp_only();
    conv(3'h5, 2'h2, 1'b0);
    rd(8'h10, 6, 0, {TR, PC});
    conv(3'h4, 2'h0, 1'b0);
    rd(8'h30, 3, 1, {24'h0, PR});
    rd(8'h11, 6, 0, {TR, AX});
  endtask

  task automatic t_bad_codes();
    int n;
    logic [7:0] bad [4] = '{8'h58, 8'h5c, 8'h41, 8'h43};
    foreach (bad[i]) begin
      cmd(bad[i]);
      wait_lvl(2, 1'b1, n);
      chk("fail flag", 48'h141, {39'h0, asleep, event_source_reg});
      conv(3'h5, 2'h2, 1'b1);
      chk("fail cleared", 48'h140, {39'h0, asleep, event_source_reg});
    end
  endtask

  task automatic t_soft_reset();
    int n;
    @(negedge clk);
    compensation_config = 1'b1;
    cmd(8'h40);
    wait_lvl(0, 1'b0, n);
    repeat (500) @(negedge clk);
    cmd(8'h06);
    wait_lvl(1, 1'b0, n);
    chk("events cleared", 48'h0, {40'h0, event_source_reg});
    wait_lvl(1, 1'b1, n);
    chk_rng("reinit cycles", INIT_N - 1, INIT_N + 2, n);
    rd(8'h10, 6, 0, 48'h0);
    rd(8'h30, 3, 0, 48'h0);
    repeat (800) @(negedge clk);
    chk("aborted work", 48'h1, {47'h0, asleep});
  endtask

  // Main sequence
  initial begin
    t_powerup();
    t_default_reads();
    t_all_codes();
    t_raw_temp_only();
    t_bad_codes();
    t_soft_reset();
    complete_run();
  end
endmodule // tb

`default_nettype wire
